// File: include/sbm_consts.vh
// Constants for one buffer manager register block: offsets, fields, resets.
// Assumes byte-wide register access with a 12-bit byte address.
`ifndef SBM_CONSTS_VH
`define SBM_CONSTS_VH
// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define SBM_BASE 12'h800
`define SBM_STRIDE 12'h008
`define SBM_OFS_START_LO 3'h0
`define SBM_OFS_START_HI 3'h1
`define SBM_OFS_LEN_LO 3'h2
`define SBM_OFS_LEN_HI 3'h3
`define SBM_OFS_CTRL 3'h4
`define SBM_OFS_STAT 3'h5
`define SBM_OFS_ACT 3'h6
`define SBM_OFS_HCTRL 3'h7
// ------------------------------------------------------------
// Field positions and codes
// ------------------------------------------------------------
`define SBM_CTRL_WDOG 6
`define SBM_CTRL_HOST_EV 5
`define SBM_CTRL_NET_EV 4
`define SBM_DIR_NET_READ 2'h0
`define SBM_DIR_NET_WRITE 2'h1
`define SBM_MODE_TRIPLE 2'h0
`define SBM_MODE_MAILBOX 2'h2
`define SBM_ACT_LATCH_HOST 7
`define SBM_ACT_LATCH_NET 6
`define SBM_ACT_REPEAT 1
`define SBM_ACT_ENABLE 0
`define SBM_HCTRL_ACK 1
`define SBM_HCTRL_DEACT 0
// ------------------------------------------------------------
// Reset values and masks
// ------------------------------------------------------------
`define SBM_CTRL_RST 8'h00
`define SBM_CTRL_MASK 8'h7F
`define SBM_ACT_RST 8'h00
`define SBM_ACT_MASK 8'hC3
`define SBM_BUF_NONE 2'h3
`define SBM_BUF_LAST 2'h2
`define SBM_LEN_MIN 16'h0002
`endif

// File: hw/sbm_buffer_tracker.v
// Buffer state of one manager: open flags, last buffer, mailbox, status flags.
// Assumes one-cycle access pulses from the main block on the same clock.
`timescale 1ns/10ps
`include "sbm_consts.vh"
module sbm_buffer_tracker (
	input wire clk, // System clock
	input wire sys_rst, // Synchronous reset, high
	input wire ce, // Clock enable
	input wire clr, // Manager inactive: hold reset state
	input wire mbx_mode, // Single-buffer mailbox mode
	input wire wr_first, // Writer touched first byte
	input wire wr_last, // Writer touched last byte
	input wire rd_first, // Reader touched first byte
	input wire rd_last, // Reader touched last byte
	output reg wr_open_q, // Write buffer opened
	output reg rd_open_q, // Read buffer opened
	output reg [1:0] last_buf_q, // Last completed buffer
	output reg mbx_full_q, // Mailbox holds data
	output reg irq_rd_q, // Read-complete flag
	output reg irq_wr_q, // Write-complete flag
	output wire wr_done, // Write buffer completed
	output wire rd_done // Read buffer completed
);
	// Mailbox refuses a new write while full and a read while empty
	assign wr_done = wr_last & wr_open_q & ~(mbx_mode & mbx_full_q);
	assign rd_done = rd_last & rd_open_q & ~(mbx_mode & ~mbx_full_q);

	// ------------------------------------------------------------
	// Buffer state
	// ------------------------------------------------------------
	// Set terms listed after clear terms so that a set wins; open flags list the clear last so it wins
	always @(posedge clk) begin
		if (sys_rst | (ce & clr)) begin
			wr_open_q <= 1'b0;
			rd_open_q <= 1'b0;
			last_buf_q <= `SBM_BUF_NONE;
			mbx_full_q <= 1'b0;
			irq_rd_q <= 1'b0;
			irq_wr_q <= 1'b0;
		end else if (ce) begin
			if (wr_first)
				wr_open_q <= 1'b1;
			if (wr_done)
				wr_open_q <= 1'b0;
			if (rd_first)
				rd_open_q <= 1'b1;
			if (rd_done)
				rd_open_q <= 1'b0;
			if (wr_done & ~mbx_mode) begin
				// Rotate 0,1,2 through the three buffers
				if (last_buf_q >= `SBM_BUF_LAST)
					last_buf_q <= 2'h0;
				else
					last_buf_q <= last_buf_q + 2'h1;
			end
			if (mbx_mode & rd_done)
				mbx_full_q <= 1'b0;
			if (mbx_mode & wr_done)
				mbx_full_q <= 1'b1;
			if (wr_first)
				irq_rd_q <= 1'b0;
			if (rd_done)
				irq_rd_q <= 1'b1;
			if (rd_first)
				irq_wr_q <= 1'b0;
			if (wr_done)
				irq_wr_q <= 1'b1;
		end
	end
endmodule

// File: hw/sync_buffer_manager_regs.v
// Control and status registers of one buffer manager plus its event outputs.
// Assumes byte register and memory access pulses from same-clock logic.
// Behaviour
// - Network writes control byte only while the manager is disabled.
// - Direction 00 network reads, 01 network writes; other codes reserved.
// - Mode 00 selects three-buffer exchange operation.
// - Mode 10 selects mailbox; status bit 3 shows empty 0, full 1.
// - Control bits 6,5,4 enable watchdog, host event, network event; reset 0.
// - Network event enable raises network event request on buffer completion.
// - Status 5:4 last written buffer, 11 none; bits 7,6 buffers open.
// - Read flag set after full read, cleared on first byte written.
// - Write flag set after full write, cleared on first byte read.
// - Host latch enable: latch event on host exchange or start access.
// - Network latch enable: latch event on network buffer exchange.
// - Enabled manager controls its area; disabled means plain memory.
// - Host read of activate byte clears the activation-changed flag.
// - Deactivate bit reads 1 when deactivated; write 1 stops, 0 resumes.
// - Length of one or less leaves manager inactive; one gives watchdog only.
// - Four managers, eight bytes each, from base 0800h.
`timescale 1ns/10ps
`include "sbm_consts.vh"
module sync_buffer_manager_regs #(
	parameter [1:0] MGR_INDEX = 2'h0, // Which of the four managers
	parameter ADDR_W = 12 // Byte address width
) (
	input wire clk, // System clock, 100 MHz
	input wire sys_rst, // Synchronous reset, high
	input wire ce, // Clock enable, freezes state when low
	input wire net_reg_wr, // Network register write strobe
	input wire net_reg_rd, // Network register read strobe
	input wire [ADDR_W-1:0] net_reg_addr, // Network register address
	input wire [7:0] net_reg_wdata, // Network write data
	output reg [7:0] net_reg_rdata_q, // Network read data
	input wire host_reg_wr, // Host register write strobe
	input wire host_reg_rd, // Host register read strobe
	input wire [ADDR_W-1:0] host_reg_addr, // Host register address
	input wire [7:0] host_reg_wdata, // Host write data
	output reg [7:0] host_reg_rdata_q, // Host read data
	input wire net_mem_wr, // Network memory write strobe
	input wire net_mem_rd, // Network memory read strobe
	input wire [15:0] net_mem_addr, // Network memory address
	input wire host_mem_wr, // Host memory write strobe
	input wire host_mem_rd, // Host memory read strobe
	input wire [15:0] host_mem_addr, // Host memory address
	output wire area_controlled, // Manager owns its area
	output wire area_locked, // Host side locked out by deactivate
	output reg net_event_req_q, // Network event request pulse
	output reg host_event_req_q, // Host event request pulse
	output reg watchdog_trigger_q, // Watchdog trigger pulse
	output reg latch_event_host_q, // Latch event from host side
	output reg latch_event_net_q, // Latch event from network side
	output reg act_changed_q // Activation changed flag
);
	// ------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------
	// Byte offset within this manager, or 4'h8 when outside it
	function [3:0] mgr_ofs;
		input [ADDR_W-1:0] a;
		reg [ADDR_W-1:0] base;
		begin
			base = `SBM_BASE + {{(ADDR_W-2){1'b0}}, MGR_INDEX} * `SBM_STRIDE;
			if (a >= base && a < base + `SBM_STRIDE)
				mgr_ofs = {1'b0, a[2:0]};
			else
				mgr_ofs = 4'h8;
		end
	endfunction

	wire [3:0] net_ofs = mgr_ofs(net_reg_addr);
	wire [3:0] host_ofs = mgr_ofs(host_reg_addr);

	// ------------------------------------------------------------
	// Register storage
	// ------------------------------------------------------------
	reg [15:0] start_q;
	reg [15:0] len_q;
	reg [7:0] ctrl_q;
	reg [7:0] act_q;
	reg ack_q;
	reg deact_q;

	wire enable = act_q[`SBM_ACT_ENABLE];
	wire [1:0] mode = ctrl_q[1:0];
	wire [1:0] dir = ctrl_q[3:2];
	wire mbx_mode = (mode == `SBM_MODE_MAILBOX);
	// Reserved codes fall back to plain memory
	wire codes_ok = (mode == `SBM_MODE_TRIPLE || mbx_mode) &&
		(dir == `SBM_DIR_NET_READ || dir == `SBM_DIR_NET_WRITE);
	wire len_ok = (len_q >= `SBM_LEN_MIN);
	wire len_one = (len_q == 16'h0001);
	assign area_controlled = enable & ~deact_q & codes_ok & len_ok;
	assign area_locked = enable & deact_q;

	wire net_w = net_reg_wr & ~net_ofs[3];
	wire host_w = host_reg_wr & ~host_ofs[3];
	wire host_r = host_reg_rd & ~host_ofs[3];
	wire cfg_w = net_w & ~enable;
	wire act_w = net_w & (net_ofs[2:0] == `SBM_OFS_ACT);
	wire [7:0] act_new = net_reg_wdata & `SBM_ACT_MASK;

	// Network writes only; host writes to bytes 0-6 are dropped
	always @(posedge clk) begin
		if (sys_rst) begin
			start_q <= 16'h0000;
			len_q <= 16'h0000;
			ctrl_q <= `SBM_CTRL_RST;
			act_q <= `SBM_ACT_RST;
		end else if (ce) begin
			if (cfg_w) begin
				case (net_ofs[2:0])
					`SBM_OFS_START_LO: start_q[7:0] <= net_reg_wdata;
					`SBM_OFS_START_HI: start_q[15:8] <= net_reg_wdata;
					`SBM_OFS_LEN_LO: len_q[7:0] <= net_reg_wdata;
					`SBM_OFS_LEN_HI: len_q[15:8] <= net_reg_wdata;
					`SBM_OFS_CTRL: ctrl_q <= net_reg_wdata & `SBM_CTRL_MASK;
					default: ;
				endcase
			end
			if (act_w)
				act_q <= act_new;
		end
	end

	// Host control byte: only the host writes it
	always @(posedge clk) begin
		if (sys_rst) begin
			ack_q <= 1'b0;
			deact_q <= 1'b0;
		end else if (ce) begin
			if (host_w && host_ofs[2:0] == `SBM_OFS_HCTRL) begin
				ack_q <= host_reg_wdata[`SBM_HCTRL_ACK];
				deact_q <= host_reg_wdata[`SBM_HCTRL_DEACT];
			end
		end
	end

	// Activation changed: set by an enable change, cleared by host read
	always @(posedge clk) begin
		if (sys_rst)
			act_changed_q <= 1'b0;
		else if (ce) begin
			if (act_w && act_new[`SBM_ACT_ENABLE] != enable)
				act_changed_q <= 1'b1; // set wins over a same-cycle read
			else if (host_r && host_ofs[2:0] == `SBM_OFS_ACT)
				act_changed_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Memory access classification
	// ------------------------------------------------------------
	wire [15:0] last_addr = start_q + len_q - 16'h0001;
	wire net_writes = (dir == `SBM_DIR_NET_WRITE);
	// Writer and reader sides follow the direction field
	wire w_acc = net_writes ? net_mem_wr : host_mem_wr;
	wire [15:0] w_addr = net_writes ? net_mem_addr : host_mem_addr;
	wire r_acc = net_writes ? host_mem_rd : net_mem_rd;
	wire [15:0] r_addr = net_writes ? host_mem_addr : net_mem_addr;
	wire run = area_controlled;
	wire wr_first = run & w_acc & (w_addr == start_q);
	wire wr_last = run & w_acc & (w_addr == last_addr);
	wire rd_first = run & r_acc & (r_addr == start_q);
	wire rd_last = run & r_acc & (r_addr == last_addr);

	wire wr_open, rd_open, mbx_full, irq_rd, irq_wr, wr_done, rd_done;
	wire [1:0] last_buf;

	sbm_buffer_tracker u_tracker (
		.clk(clk),
		.sys_rst(sys_rst),
		.ce(ce),
		.clr(~run),
		.mbx_mode(mbx_mode),
		.wr_first(wr_first),
		.wr_last(wr_last),
		.rd_first(rd_first),
		.rd_last(rd_last),
		.wr_open_q(wr_open),
		.rd_open_q(rd_open),
		.last_buf_q(last_buf),
		.mbx_full_q(mbx_full),
		.irq_rd_q(irq_rd),
		.irq_wr_q(irq_wr),
		.wr_done(wr_done),
		.rd_done(rd_done)
	);

	// ------------------------------------------------------------
	// Events
	// ------------------------------------------------------------
	wire done = wr_done | rd_done;
	wire net_done = net_writes ? wr_done : rd_done;
	wire host_done = net_writes ? rd_done : wr_done;
	wire host_start = host_mem_wr | host_mem_rd;
	wire host_at_start = host_start & (host_mem_addr == start_q);
	// A one-byte area only feeds the watchdog from writes to its byte
	wire wdog_src = len_one ? (enable & ~deact_q & w_acc & (w_addr == start_q)) : wr_done;

	// One-cycle event pulses
	always @(posedge clk) begin
		if (sys_rst) begin
			net_event_req_q <= 1'b0;
			host_event_req_q <= 1'b0;
			watchdog_trigger_q <= 1'b0;
			latch_event_host_q <= 1'b0;
			latch_event_net_q <= 1'b0;
		end else if (ce) begin
			net_event_req_q <= ctrl_q[`SBM_CTRL_NET_EV] & done;
			host_event_req_q <= ctrl_q[`SBM_CTRL_HOST_EV] & done;
			watchdog_trigger_q <= ctrl_q[`SBM_CTRL_WDOG] & wdog_src;
			latch_event_host_q <= act_q[`SBM_ACT_LATCH_HOST] & (host_done | (run & host_at_start));
			latch_event_net_q <= act_q[`SBM_ACT_LATCH_NET] & net_done;
		end
	end

	// ------------------------------------------------------------
	// Read back
	// ------------------------------------------------------------
	// Mode-specific status fields read zero in the other mode
	wire [7:0] status = {wr_open, rd_open, mbx_mode ? 2'h0 : last_buf,
		mbx_mode & mbx_full, 1'b0, irq_rd, irq_wr};
	wire [7:0] hctrl = {6'h00, ack_q, area_locked};

	function [7:0] reg_mux;
		input [3:0] o;
		begin
			case (o)
				{1'b0, `SBM_OFS_START_LO}: reg_mux = start_q[7:0];
				{1'b0, `SBM_OFS_START_HI}: reg_mux = start_q[15:8];
				{1'b0, `SBM_OFS_LEN_LO}: reg_mux = len_q[7:0];
				{1'b0, `SBM_OFS_LEN_HI}: reg_mux = len_q[15:8];
				{1'b0, `SBM_OFS_CTRL}: reg_mux = ctrl_q;
				{1'b0, `SBM_OFS_STAT}: reg_mux = status;
				{1'b0, `SBM_OFS_ACT}: reg_mux = act_q;
				{1'b0, `SBM_OFS_HCTRL}: reg_mux = hctrl;
				default: reg_mux = 8'h00;
			endcase
		end
	endfunction

	// Data registered on the read strobe, held until the next read
	always @(posedge clk) begin
		if (sys_rst) begin
			net_reg_rdata_q <= 8'h00;
			host_reg_rdata_q <= 8'h00;
		end else if (ce) begin
			if (net_reg_rd)
				net_reg_rdata_q <= reg_mux(net_ofs);
			if (host_reg_rd)
				host_reg_rdata_q <= reg_mux(host_ofs);
		end
	end
endmodule

// File: verification/sync_buffer_manager_regs_properties.sv
// Checker for one buffer manager: event pulses, lock and activation flag.
// Assumes it is bound to the register block and sees only its ports.
`timescale 1ns/10ps
module sync_buffer_manager_regs_properties #(
	parameter [1:0] MGR_INDEX = 2'h0, // Manager index of the bound block
	parameter ADDR_W = 12 // Byte address width
) (
	input wire clk, // System clock
	input wire sys_rst, // Synchronous reset
	input wire net_reg_wr, // Network register write
	input wire host_reg_rd, // Host register read
	input wire [ADDR_W-1:0] host_reg_addr, // Host register address
	input wire net_mem_wr, // Network memory write
	input wire net_mem_rd, // Network memory read
	input wire host_mem_wr, // Host memory write
	input wire host_mem_rd, // Host memory read
	input wire area_controlled, // Manager owns area
	input wire area_locked, // Host locked out
	input wire net_event_req_q, // Network event pulse
	input wire watchdog_trigger_q, // Watchdog pulse
	input wire latch_event_host_q, // Host latch pulse
	input wire latch_event_net_q, // Network latch pulse
	input wire act_changed_q // Activation changed
);
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	localparam [11:0] BASE = 12'h800 + {MGR_INDEX, 3'h0};
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Network and watchdog pulses last one cycle; network, watchdog and both latch pulses follow an access to the buffer memory
	property p_net_pulse; net_event_req_q |=> !net_event_req_q; endproperty
	a_net_pulse: assert property (p_net_pulse) else $error("net event longer than one cycle");
	property p_net_cause; net_event_req_q |-> $past(net_mem_wr || net_mem_rd || host_mem_wr || host_mem_rd); endproperty
	a_net_cause: assert property (p_net_cause) else $error("net event without access");
	property p_latch_net; latch_event_net_q |-> $past(net_mem_wr || net_mem_rd); endproperty
	a_latch_net: assert property (p_latch_net) else $error("net latch without net access");
	property p_latch_host; latch_event_host_q |-> $past(host_mem_wr || host_mem_rd); endproperty
	a_latch_host: assert property (p_latch_host) else $error("host latch without host access");
	property p_wdog; watchdog_trigger_q |-> $past(net_mem_wr || host_mem_wr) ##1 !watchdog_trigger_q; endproperty
	a_wdog: assert property (p_wdog) else $error("bad watchdog pulse");
	property p_lock; area_locked |-> !area_controlled; endproperty
	a_lock: assert property (p_lock) else $error("locked area still controlled");
	property p_act_set; $rose(act_changed_q) |-> $past(net_reg_wr); endproperty
	a_act_set: assert property (p_act_set) else $error("activation flag set without write");
	property p_act_clr;
		$fell(act_changed_q) |-> $past(host_reg_rd && host_reg_addr == BASE + 12'h006) || $past(sys_rst);
	endproperty
	a_act_clr: assert property (p_act_clr) else $error("activation flag cleared without read");
	c_net: cover property (net_event_req_q);
	c_host_latch: cover property (latch_event_host_q);
	c_lock: cover property (area_locked);
endmodule

// File: verification/sbm_partner.sv
// Far-side model: network master and local host issuing byte accesses.
// Assumes the bench calls its tasks; drives move at the falling edge.
`timescale 1ns/10ps
module sbm_partner (
	input wire clk, // System clock
	output logic net_reg_wr, // Network register write
	output logic net_reg_rd, // Network register read
	output logic [11:0] net_reg_addr, // Network register address
	output logic [7:0] net_reg_wdata, // Network write data
	output logic host_reg_wr, // Host register write
	output logic host_reg_rd, // Host register read
	output logic [11:0] host_reg_addr, // Host register address
	output logic [7:0] host_reg_wdata, // Host write data
	output logic net_mem_wr, // Network memory write
	output logic net_mem_rd, // Network memory read
	output logic [15:0] net_mem_addr, // Network memory address
	output logic host_mem_wr, // Host memory write
	output logic host_mem_rd, // Host memory read
	output logic [15:0] host_mem_addr // Host memory address
);
	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	// Idle buses start at zero, then show inverted values so stale data is never mistaken for fresh
	initial begin
		{net_reg_wr, net_reg_rd, net_reg_addr, net_reg_wdata} = 22'h0;
		{host_reg_wr, host_reg_rd, host_reg_addr, host_reg_wdata} = 22'h0;
		{net_mem_wr, net_mem_rd, net_mem_addr, host_mem_wr, host_mem_rd, host_mem_addr} = 36'h0;
	end
	task reg_acc(input logic host, input logic wr, input logic [11:0] a, input logic [7:0] d);
		@(negedge clk);
		if (host) {host_reg_wr, host_reg_rd, host_reg_addr, host_reg_wdata} = {wr, !wr, a, d};
		else {net_reg_wr, net_reg_rd, net_reg_addr, net_reg_wdata} = {wr, !wr, a, d};
		@(negedge clk);
		if (host) {host_reg_wr, host_reg_rd, host_reg_addr, host_reg_wdata} = {2'b00, ~a, ~d};
		else {net_reg_wr, net_reg_rd, net_reg_addr, net_reg_wdata} = {2'b00, ~a, ~d};
	endtask
	task mem_acc(input logic host, input logic wr, input logic [15:0] a);
		@(negedge clk);
		if (host) {host_mem_wr, host_mem_rd, host_mem_addr} = {wr, !wr, a};
		else {net_mem_wr, net_mem_rd, net_mem_addr} = {wr, !wr, a};
		@(negedge clk);
		if (host) {host_mem_wr, host_mem_rd, host_mem_addr} = {2'b00, ~a};
		else {net_mem_wr, net_mem_rd, net_mem_addr} = {2'b00, ~a};
	endtask
endmodule

// File: verification/sync_buffer_manager_regs_tb_top.sv
// Bench for manager 0: register map, buffer status, events and lock.
// Assumes the partner model drives all access strobes.
`timescale 1ns/10ps
module sync_buffer_manager_regs_tb_top;
	localparam [11:0] B = 12'h800;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic ce = 1'b1;
	wire net_reg_wr, net_reg_rd, host_reg_wr, host_reg_rd, net_mem_wr, net_mem_rd, host_mem_wr, host_mem_rd;
	wire [11:0] net_reg_addr, host_reg_addr;
	wire [7:0] net_reg_wdata, host_reg_wdata, net_reg_rdata_q, host_reg_rdata_q;
	wire [15:0] net_mem_addr, host_mem_addr;
	wire area_controlled, area_locked, net_event_req_q, host_event_req_q, watchdog_trigger_q;
	wire latch_event_host_q, latch_event_net_q, act_changed_q;
	integer n_errors = 0, samples_checked = 0, seed = 57000;
	logic [8:0] exp_q[$]; // Bit 8 marks a host-side read
	logic rd_seen = 1'b0;
	logic [7:0] n_net = 8'h00, n_host = 8'h00, n_wd = 8'h00, n_lh = 8'h00, n_ln = 8'h00, d;
	always #5 clk = ~clk;
	sync_buffer_manager_regs i_dut (.clk, .sys_rst, .ce, .net_reg_wr, .net_reg_rd, .net_reg_addr,
		.net_reg_wdata, .net_reg_rdata_q, .host_reg_wr, .host_reg_rd, .host_reg_addr, .host_reg_wdata,
		.host_reg_rdata_q, .net_mem_wr, .net_mem_rd, .net_mem_addr, .host_mem_wr, .host_mem_rd, .host_mem_addr,
		.area_controlled, .area_locked, .net_event_req_q, .host_event_req_q, .watchdog_trigger_q,
		.latch_event_host_q, .latch_event_net_q, .act_changed_q);
	sbm_partner i_partner (.clk, .net_reg_wr, .net_reg_rd, .net_reg_addr, .net_reg_wdata, .host_reg_wr,
		.host_reg_rd, .host_reg_addr, .host_reg_wdata, .net_mem_wr, .net_mem_rd, .net_mem_addr, .host_mem_wr,
		.host_mem_rd, .host_mem_addr);
	// ----------------------------------------
	// Checking
	// ----------------------------------------
	task check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		samples_checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task end_of_test;
		$display("Checked %0d samples, %0d mismatches", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task wr(input logic host, input logic [3:0] o, input logic [7:0] v);
		i_partner.reg_acc(host, 1'b1, B + o, v);
	endtask
	task rd(input logic host, input logic [3:0] o, input logic [7:0] e);
		exp_q.push_back({host, e});
		i_partner.reg_acc(host, 1'b0, B + o, 8'h00);
	endtask
	// Count single-cycle event pulses so totals can be compared later
	always @(posedge clk) begin
		rd_seen <= net_reg_rd | host_reg_rd;
		n_net <= n_net + net_event_req_q;
		n_host <= n_host + host_event_req_q;
		n_wd <= n_wd + watchdog_trigger_q;
		n_lh <= n_lh + latch_event_host_q;
		n_ln <= n_ln + latch_event_net_q;
	end
	// Read data settles after the strobe edge; compare against the oldest note
	always @(negedge clk) if (rd_seen) begin : mon
		logic [8:0] e;
		e = exp_q.pop_front();
		check(e[8] ? host_reg_rdata_q : net_reg_rdata_q, e[7:0], "register read");
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		end_of_test;
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk);
		@(negedge clk) sys_rst = 1'b0;
		rd(1, 4, 8'h00);
		rd(1, 5, 8'h30);
		rd(1, 6, 8'h00);
		rd(1, 7, 8'h00);
		d = 8'($random(seed));
		wr(0, 1, d);
		rd(0, 1, d);
		rd(1, 4'h8, 8'h00);
		$display("test reset and map done");
		wr(0, 4, 8'hFF);
		rd(0, 4, 8'h7F);
		wr(0, 4, 8'h14);
		wr(1, 4, 8'h00);
		rd(1, 4, 8'h14);
		wr(0, 0, 8'h00);
		wr(0, 1, 8'h01);
		wr(0, 2, 8'h04);
		wr(0, 3, 8'h00);
		wr(0, 6, 8'hFF);
		check({7'h00, act_changed_q}, 8'h01, "activation changed");
		rd(1, 6, 8'hC3);
		check({7'h00, act_changed_q}, 8'h00, "activation changed");
		wr(0, 4, 8'h00);
		rd(0, 4, 8'h14);
		check({7'h00, area_controlled}, 8'h01, "area controlled");
		$display("test control done");
		i_partner.mem_acc(0, 1, 16'h0100);
		rd(1, 5, 8'hB0);
		i_partner.mem_acc(0, 1, 16'h0103);
		rd(1, 5, 8'h01);
		i_partner.mem_acc(1, 0, 16'h0100);
		rd(1, 5, 8'h40);
		i_partner.mem_acc(1, 0, 16'h0103);
		rd(1, 5, 8'h02);
		check(n_net, 8'h02, "network events");
		check(n_ln, 8'h01, "network latch events");
		check(n_lh, 8'h02, "host latch events");
		check(n_host + n_wd, 8'h00, "disabled events");
		$display("test three buffer done");
		wr(1, 7, 8'h01);
		rd(1, 7, 8'h01);
		check({6'h00, area_locked, area_controlled}, 8'h02, "lock state");
		wr(0, 7, 8'h00);
		rd(1, 7, 8'h01);
		wr(1, 7, 8'h02);
		rd(1, 7, 8'h02);
		wr(0, 6, 8'hC1);
		rd(0, 6, 8'hC1);
		$display("test deactivate and repeat done");
		wr(0, 6, 8'h00);
		wr(0, 4, 8'h06);
		wr(0, 6, 8'h01);
		i_partner.mem_acc(0, 1, 16'h0100);
		i_partner.mem_acc(0, 1, 16'h0103);
		rd(1, 5, 8'h09);
		i_partner.mem_acc(1, 0, 16'h0100);
		i_partner.mem_acc(1, 0, 16'h0103);
		rd(1, 5, 8'h02);
		wr(0, 6, 8'h00);
		wr(0, 4, 8'h01);
		wr(0, 6, 8'h01);
		check({7'h00, area_controlled}, 8'h00, "reserved mode");
		$display("test mailbox done");
		// Watchdog and host event on a write completion, then a one-byte area
		wr(0, 6, 8'h00);
		wr(0, 4, 8'h64);
		wr(0, 6, 8'h01);
		i_partner.mem_acc(0, 1, 16'h0100);
		i_partner.mem_acc(0, 1, 16'h0103);
		@(negedge clk);
		check(n_host, 8'h01, "host events");
		check(n_wd, 8'h01, "watchdog triggers");
		wr(0, 6, 8'h00);
		wr(0, 2, 8'h01);
		wr(0, 6, 8'h01);
		check({7'h00, area_controlled}, 8'h00, "one byte area");
		i_partner.mem_acc(0, 1, 16'h0100);
		@(negedge clk);
		check(n_wd, 8'h02, "watchdog triggers");
		// A write while the clock enable is low must leave the manager enabled
		ce = 1'b0;
		wr(0, 6, 8'h00);
		ce = 1'b1;
		rd(0, 6, 8'h01);
		$display("test watchdog and clock enable done");
		repeat (3) @(posedge clk);
		end_of_test;
	end
endmodule
bind sync_buffer_manager_regs sync_buffer_manager_regs_properties #(.MGR_INDEX(MGR_INDEX), .ADDR_W(ADDR_W)) i_props (
	.clk, .sys_rst, .net_reg_wr, .host_reg_rd, .host_reg_addr, .net_mem_wr, .net_mem_rd, .host_mem_wr,
	.host_mem_rd, .area_controlled, .area_locked, .net_event_req_q, .watchdog_trigger_q, .latch_event_host_q,
	.latch_event_net_q, .act_changed_q);
